// ==== logic/emc_pkg.sv ====
// Purpose: shared constants and types of the engraver mode controller
// Assumes: one 50 MHz clock, asynchronous active-low reset
// Notes:   speeds in mm/s, override in percent, data in bytes
//
// Behaviour
// - power-up always lands in stop mode
// - settings key in stop enters settings
// - run key in stop enters start
// - run key while engraving aborts to stop
// - abort: XY halt, Z lifts, spindle off
// - start mode buffers and executes host data
// - ten seconds idle: next data overwrites
// - override 50..200 percent scales all speeds
// - plus/minus step override by ten percent
// - override keys work only in start
// - axis speed clamped at 85 mm/s
// - emergency stop cuts power, discards buffer
// - power request ignored while latch engaged
// - latch release leaves power off
// - start display: mode, kB, override, speed
// - confirm executes, exit cancels item action
// - settings shows page; up/down step pages
// - run key in start returns to stop
`default_nettype none
package emc_pkg;

    typedef enum logic [1:0] {
        EMC_STOP  = 2'h0,
        EMC_START = 2'h1,
        EMC_SET   = 2'h3,
        EMC_LIFT  = 2'h2
    } emc_mode_t;

    // synchronised pin vector layout
    localparam int PIN_W     = 11;
    localparam int K_RUN     = 0;
    localparam int K_SET     = 1;
    localparam int K_EXIT    = 2;
    localparam int K_ENTER   = 3;
    localparam int K_UP      = 4;
    localparam int K_DOWN    = 5;
    localparam int K_PLUS    = 6;
    localparam int K_MINUS   = 7;
    localparam int P_ESTOP   = 8;
    localparam int P_PWRREQ  = 9;
    localparam int P_ZTOP    = 10;

    localparam int DATA_W    = 8;
    localparam int BUF_DEPTH = 2;
    localparam int CNT_W     = 20;
    localparam int KB_SHIFT  = 10;
    localparam int KB_W      = CNT_W - KB_SHIFT;

    localparam logic [7:0]  PCT_RESET = 8'h64;
    localparam logic [7:0]  PCT_MIN   = 8'h32;
    localparam logic [7:0]  PCT_MAX   = 8'hC8;
    localparam logic [7:0]  PCT_STEP  = 8'h0A;
    localparam logic [15:0] PCT_DIV   = 16'h0064;
    localparam logic [7:0]  SPEED_MAX = 8'h55;

    localparam logic [3:0]  PAGE_FIRST = 4'h1;
    localparam logic [3:0]  PAGE_TOTAL = 4'hA;

    localparam int IDLE_TIME_S = 32'h0000_000A;
    localparam int CLK_HZ      = 32'h02FA_F080;
    localparam int IDLE_CYCLES = IDLE_TIME_S * CLK_HZ;
    localparam int IDLE_W      = 29;

endpackage
`default_nettype wire

// ==== logic/emc_rx_buffer.sv ====
// Purpose: small reception buffer between host and motion engine
// Assumes: same clock as its neighbours
// Notes:   ready and valid are registered; flush may coincide with a push
`timescale 1ns/1ns
`default_nettype none
module emc_rx_buffer #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    // control
    input  wire logic         flush_in,
    input  wire logic         enable_in,
    // fill side
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output var  logic         in_ready_out,
    // drain side
    output var  logic         out_valid_out,
    output logic      [W-1:0] out_data_out,
    input  wire logic         out_ready_in
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          push;
    logic          pop;
    logic [PW-1:0] wr_at;

    function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
        nxt = (p == LAST) ? '0 : p + PW'(1);
    endfunction

    assign push         = in_valid_in && in_ready_out;
    assign pop          = out_valid_out && out_ready_in && !flush_in;
    assign wr_at        = flush_in ? '0 : wr_q;
    assign out_data_out = mem_q[rd_q];

    always_comb begin
        if (flush_in) begin
            cnt_d = push ? CW'(1) : '0;
        end else begin
            cnt_d = cnt_q + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_q         <= '0;
            wr_q          <= '0;
            rd_q          <= '0;
            out_valid_out <= 1'b0;
            in_ready_out  <= 1'b0;
        end else begin
            cnt_q         <= cnt_d;
            out_valid_out <= (cnt_d != '0);
            // ready follows enable a cycle late: one more byte may land
            in_ready_out  <= (cnt_d != FULL) && enable_in && !flush_in;
            if (push) begin
                wr_q <= nxt(wr_at);
            end else if (flush_in) begin
                wr_q <= '0;
            end
            if (flush_in) begin
                rd_q <= '0;
            end else if (pop) begin
                rd_q <= nxt(rd_q);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_at] <= in_data_in;
        end
    end

endmodule
`default_nettype wire

// ==== logic/emc_top.sv ====
// Purpose: operating-mode controller of a desktop engraving machine
// Assumes: panel keys, emergency latch, power request and Z-top switch are
//          asynchronous pins; host bytes and motion handshake share clk_in
// Notes:   modes stop, start, settings, plus a lift state for aborts
`timescale 1ns/1ns
`default_nettype none
module emc_top
    import emc_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES_P = emc_pkg::IDLE_CYCLES
) (
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        resetn_in,
    // operator panel keys (pins)
    input  wire logic                        key_run_in,
    input  wire logic                        key_settings_in,
    input  wire logic                        key_exit_in,
    input  wire logic                        key_enter_in,
    input  wire logic                        key_up_in,
    input  wire logic                        key_down_in,
    input  wire logic                        key_plus_in,
    input  wire logic                        key_minus_in,
    // power and safety (pins)
    input  wire logic                        estop_latched_in,
    input  wire logic                        power_req_in,
    input  wire logic                        z_at_top_in,
    // settings menu and motion engine
    input  wire logic                        item_has_action_in,
    input  wire logic [7:0]                  cfg_speed_in,
    input  wire logic                        motion_busy_in,
    // host data stream
    input  wire logic                        host_valid_in,
    input  wire logic [emc_pkg::DATA_W-1:0]  host_data_in,
    output var  logic                        host_ready_out,
    // moves to motion engine
    output var  logic                        move_valid_out,
    output logic      [emc_pkg::DATA_W-1:0]  move_data_out,
    input  wire logic                        move_ready_in,
    // machine drive
    output var  logic                        power_on_out,
    output var  logic                        xy_halt_out,
    output var  logic                        z_lift_out,
    output var  logic                        spindle_en_out,
    output var  logic                        exec_start_out,
    output var  logic                        exec_cancel_out,
    // display fields
    output var  emc_pkg::emc_mode_t          mode_out,
    output var  logic [emc_pkg::KB_W-1:0]    buffered_kb_out,
    output var  logic [7:0]                  override_pct_out,
    output var  logic [7:0]                  axis_speed_out,
    output var  logic [3:0]                  page_out,
    output var  logic [3:0]                  page_total_out
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and key edges

    logic [PIN_W-1:0] meta_q;
    logic [PIN_W-1:0] sync_q;
    logic [PIN_W-1:0] last_q;
    logic [PIN_W-1:0] pins;
    logic [PIN_W-1:0] press;

    assign pins = {z_at_top_in, power_req_in, estop_latched_in,
                   key_minus_in, key_plus_in, key_down_in, key_up_in,
                   key_enter_in, key_exit_in, key_settings_in, key_run_in};

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign press = sync_q & ~last_q;

    logic estop;
    logic run_p;
    logic exit_p;

    assign estop  = sync_q[P_ESTOP];
    assign run_p  = press[K_RUN];
    assign exit_p = press[K_EXIT];

    ////////////////////////////////////////////////////////////////////////////
    // power latch

    logic power_q;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            power_q <= 1'b1;
        end else if (estop) begin
            power_q <= 1'b0;
        end else if (press[P_PWRREQ]) begin
            power_q <= 1'b1;
        end
    end

    assign power_on_out = power_q;

    ////////////////////////////////////////////////////////////////////////////
    // mode sequencer

    emc_mode_t mode_q;
    emc_mode_t mode_d;
    logic      busy;

    assign busy = move_valid_out || motion_busy_in;

    always_comb begin
        mode_d = mode_q;
        if (!power_q || estop) begin
            mode_d = EMC_STOP;
        end else begin
            unique case (mode_q)
                EMC_STOP: begin
                    if (run_p) begin
                        mode_d = EMC_START;
                    end else if (press[K_SET]) begin
                        mode_d = EMC_SET;
                    end
                end
                EMC_START: begin
                    if (run_p) begin
                        // a running job must lift Z before stop
                        mode_d = busy ? EMC_LIFT : EMC_STOP;
                    end
                end
                EMC_LIFT: begin
                    if (sync_q[P_ZTOP]) begin
                        mode_d = EMC_STOP;
                    end
                end
                EMC_SET: begin
                    if (exit_p && !item_has_action_in) begin
                        mode_d = EMC_STOP;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_q         <= EMC_STOP;
            xy_halt_out    <= 1'b1;
            z_lift_out     <= 1'b0;
            spindle_en_out <= 1'b0;
        end else begin
            mode_q         <= mode_d;
            xy_halt_out    <= (mode_d != EMC_START);
            z_lift_out     <= (mode_d == EMC_LIFT);
            spindle_en_out <= (mode_d == EMC_START);
        end
    end

    assign mode_out = mode_q;

    ////////////////////////////////////////////////////////////////////////////
    // reception buffer, byte count and idle overwrite

    logic              take_en;
    logic              push;
    logic              flush;
    logic              stale_q;
    logic [IDLE_W-1:0] idle_q;
    logic [CNT_W-1:0]  count_q;

    assign take_en = power_q && !estop && (mode_d == EMC_START);
    assign push    = host_valid_in && host_ready_out;
    // a byte taken exactly at the idle limit already counts as late
    assign flush   = estop || (push && (stale_q || idle_q >= IDLE_W'(IDLE_CYCLES_P - 1)));

    emc_rx_buffer #(
        .W     (DATA_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_in        (clk_in),
        .resetn_in     (resetn_in),
        .flush_in      (flush),
        .enable_in     (take_en),
        .in_valid_in   (host_valid_in && !estop),
        .in_data_in    (host_data_in),
        .in_ready_out  (host_ready_out),
        .out_valid_out (move_valid_out),
        .out_data_out  (move_data_out),
        .out_ready_in  (move_ready_in && (mode_q == EMC_START))
    );

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            idle_q  <= '0;
            stale_q <= 1'b0;
        end else if (push || mode_q != EMC_START) begin
            idle_q  <= '0;
            stale_q <= 1'b0;
        end else if (idle_q >= IDLE_W'(IDLE_CYCLES_P - 1)) begin
            stale_q <= 1'b1;
        end else begin
            idle_q  <= idle_q + IDLE_W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_q <= '0;
        end else if (flush) begin
            // estop discards even a byte taken in the same cycle
            count_q <= (push && !estop) ? CNT_W'(1) : '0;
        end else if (push) begin
            count_q <= count_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            buffered_kb_out <= '0;
        end else begin
            buffered_kb_out <= count_q[CNT_W-1:KB_SHIFT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // speed override and clamp

    logic [7:0]  pct_q;
    logic [15:0] scaled;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pct_q <= PCT_RESET;
        end else if (mode_q == EMC_START && power_q) begin
            if (press[K_PLUS] && pct_q < PCT_MAX) begin
                pct_q <= pct_q + PCT_STEP;
            end else if (press[K_MINUS] && pct_q > PCT_MIN) begin
                pct_q <= pct_q - PCT_STEP;
            end
        end
    end

    // the divide is by a constant, so it folds to a multiply network
    assign scaled = (16'(cfg_speed_in) * 16'(pct_q)) / PCT_DIV;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            axis_speed_out   <= '0;
            override_pct_out <= PCT_RESET;
        end else begin
            axis_speed_out   <= (scaled > 16'(SPEED_MAX)) ? SPEED_MAX : scaled[7:0];
            override_pct_out <= pct_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings pages and item actions

    logic [3:0] page_q;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            page_q <= PAGE_FIRST;
        end else if (mode_q == EMC_SET) begin
            if (press[K_DOWN] && page_q < PAGE_TOTAL) begin
                page_q <= page_q + 4'h1;
            end else if (press[K_UP] && page_q > PAGE_FIRST) begin
                page_q <= page_q - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            page_out        <= PAGE_FIRST;
            page_total_out  <= PAGE_TOTAL;
            exec_start_out  <= 1'b0;
            exec_cancel_out <= 1'b0;
        end else begin
            page_out        <= page_q;
            page_total_out  <= PAGE_TOTAL;
            exec_start_out  <= (mode_q == EMC_SET) && item_has_action_in && press[K_ENTER];
            exec_cancel_out <= (mode_q == EMC_SET) && item_has_action_in && exit_p;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    logic live;
    assign live = power_q && !estop;

    sequence s_abort_req;
        mode_q == EMC_START && run_p && busy && live;
    endsequence

    sequence s_lifting;
        mode_q == EMC_LIFT && z_lift_out && xy_halt_out && !spindle_en_out;
    endsequence

    a_stop_to_start: assert property (mode_q == EMC_STOP && run_p && live |=> mode_q == EMC_START)
        else $error("run key in stop did not enter start");
    a_stop_to_set: assert property (mode_q == EMC_STOP && !run_p && press[K_SET] && live
                                    |=> mode_q == EMC_SET)
        else $error("settings key in stop did not enter settings");
    a_abort_lift: assert property (s_abort_req |=> s_lifting)
        else $error("abort did not lift Z with XY halted");
    a_lift_end: assert property (mode_q == EMC_LIFT && sync_q[P_ZTOP] |=> mode_q == EMC_STOP)
        else $error("lift did not stop at Z top");
    a_override_range: assert property (pct_q >= PCT_MIN && pct_q <= PCT_MAX)
        else $error("override out of range");
    a_override_hold: assert property (mode_q != EMC_START |=> $stable(pct_q))
        else $error("override changed outside start");
    a_override_step: assert property (mode_q == EMC_START && power_q && press[K_PLUS] && pct_q < PCT_MAX
                                      |=> pct_q == $past(pct_q) + PCT_STEP)
        else $error("override did not step up by ten");
    a_speed_clamp: assert property (axis_speed_out <= SPEED_MAX)
        else $error("axis speed above limit");
    a_estop_cut: assert property (estop |=> !power_q && count_q == '0 && !move_valid_out)
        else $error("emergency stop left power or data");
    a_release_off: assert property ($fell(estop) && !press[P_PWRREQ] && !power_q |=> !power_q)
        else $error("latch release restored power");
    a_page_range: assert property (page_q >= PAGE_FIRST && page_q <= PAGE_TOTAL)
        else $error("page out of range");

endmodule
`default_nettype wire

// ==== verification/emc_host_model.sv ====
// Purpose: host computer model feeding engraving bytes over valid/ready
// Assumes: shares clk_in with the controller
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module emc_host_model (
    // clock
    input  wire logic       clk_in,
    // byte stream
    input  wire logic       host_ready_in,
    output var  logic       host_valid_out,
    output var  logic [7:0] host_data_out
);
    initial begin
        host_valid_out = 1'b0;
        host_data_out  = 8'hA5;
    end
    ////////////////////////////////////////////////////////////////////////////
    // hold valid and data up to the edge that samples ready high
    task automatic send(input logic [7:0] b, output bit ok);
        ok = 1'b0;
        @(posedge clk_in);
        #2;
        host_valid_out = 1'b1;
        host_data_out  = b;
        for (int i = 0; i < 400; i++) begin
            if (host_ready_in === 1'b1) begin
                @(posedge clk_in);
                ok = 1'b1;
                break;
            end
            @(posedge clk_in);
            #2;
        end
        #2;
        host_valid_out = 1'b0;
        // a stale byte left on the lines could hide a double take
        host_data_out  = ~b;
    endtask
endmodule
`default_nettype wire

// ==== verification/emc_top_test.sv ====
// Purpose: self-checking bench of the engraver mode controller
// Assumes: idle limit shortened to 50 cycles
// Notes:   keys are held 4 cycles, then released 6 cycles
`timescale 1ns/1ns
`default_nettype none
module emc_top_test;
    import emc_pkg::*;
    logic clk_in = 1'b0, resetn_in = 1'b0;
    logic [7:0] key_pins = 8'h00;
    logic estop_latched_in = 1'b0, power_req_in = 1'b0, z_at_top_in = 1'b0;
    logic item_has_action_in = 1'b0, motion_busy_in = 1'b0, move_ready_in = 1'b1;
    logic [7:0] cfg_speed_in = 8'h3C;
    logic host_valid_in, host_ready_out, move_valid_out, power_on_out;
    logic [7:0] host_data_in, move_data_out, override_pct_out, axis_speed_out;
    logic xy_halt_out, z_lift_out, spindle_en_out, exec_start_out, exec_cancel_out;
    emc_mode_t mode_out;
    logic [KB_W-1:0] buffered_kb_out;
    logic [3:0] page_out, page_total_out;
    int miscompares = 0, tests_run = 0, pops = 0, starts = 0, cancels = 0;
    logic [7:0] exp_q[$];
    bit ok;

    always #10 clk_in = ~clk_in;

    emc_top #(.IDLE_CYCLES_P(50)) i_emc_top (.clk_in, .resetn_in,
        .key_run_in(key_pins[K_RUN]), .key_settings_in(key_pins[K_SET]),
        .key_exit_in(key_pins[K_EXIT]), .key_enter_in(key_pins[K_ENTER]),
        .key_up_in(key_pins[K_UP]), .key_down_in(key_pins[K_DOWN]),
        .key_plus_in(key_pins[K_PLUS]), .key_minus_in(key_pins[K_MINUS]),
        .estop_latched_in, .power_req_in, .z_at_top_in, .item_has_action_in,
        .cfg_speed_in, .motion_busy_in, .host_valid_in, .host_data_in,
        .host_ready_out, .move_valid_out, .move_data_out, .move_ready_in,
        .power_on_out, .xy_halt_out, .z_lift_out, .spindle_en_out,
        .exec_start_out, .exec_cancel_out, .mode_out, .buffered_kb_out,
        .override_pct_out, .axis_speed_out, .page_out, .page_total_out);

    emc_host_model i_emc_host_model (.clk_in, .host_ready_in(host_ready_out),
        .host_valid_out(host_valid_in), .host_data_out(host_data_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic press(input int k);
        @(posedge clk_in);
        #2;
        key_pins[k] = 1'b1;
        repeat (4) @(posedge clk_in);
        #2;
        key_pins[k] = 1'b0;
        repeat (6) @(posedge clk_in);
        #2;
    endtask

    task automatic pulse_power;
        power_req_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #2;
        power_req_in = 1'b0;
        repeat (6) @(posedge clk_in);
        #2;
    endtask

    task automatic put_byte(input logic [7:0] b);
        exp_q.push_back(b);
        i_emc_host_model.send(b, ok);
        if (!ok) begin
            miscompares++;
            $display("ERROR at %0t: host byte never taken", $time);
            end_sim();
        end
    endtask

    function automatic logic [31:0] speed(input int cfg, input int pct);
        return (cfg * pct / 100 > 85) ? 32'd85 : 32'(cfg * pct / 100);
    endfunction

    // every move handed over must be the next byte the host sent
    always @(posedge clk_in) begin
        if (resetn_in && move_valid_out === 1'b1 && move_ready_in && mode_out === EMC_START) begin
            pops++;
            if (exp_q.size() == 0) begin
                chk(1, 0, "move with nothing sent");
            end else begin
                chk(move_data_out, exp_q.pop_front(), "move byte");
            end
        end
        if (exec_start_out === 1'b1) starts++;
        if (exec_cancel_out === 1'b1) cancels++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_idle_keys;
        chk(mode_out, EMC_STOP, "mode after reset");
        chk(power_on_out, 1, "power after reset");
        chk({page_out, page_total_out}, {PAGE_FIRST, PAGE_TOTAL}, "pages");
        press(K_PLUS);
        chk(override_pct_out, PCT_RESET, "plus in stop");
    endtask

    task automatic t_override;
        press(K_RUN);
        chk(mode_out, EMC_START, "run in stop");
        chk({xy_halt_out, spindle_en_out}, 2'b01, "drive in start");
        press(K_PLUS);
        chk({override_pct_out, axis_speed_out}, {8'd110, 8'd66}, "one step");
        repeat (10) press(K_PLUS);
        chk(override_pct_out, PCT_MAX, "upper limit");
        chk(axis_speed_out, speed(60, 200), "speed clamp");
        repeat (16) press(K_MINUS);
        chk(override_pct_out, PCT_MIN, "lower limit");
        chk(axis_speed_out, speed(60, 50), "half speed");
        repeat (5) press(K_PLUS);
    endtask

    task automatic t_stream;
        move_ready_in = 1'b0;
        put_byte(8'h11);
        put_byte(8'h22);
        fork
            put_byte(8'h33);
            begin
                repeat (12) @(posedge clk_in);
                #2;
                chk(host_ready_out, 0, "ready when full");
                move_ready_in = 1'b1;
            end
        join
        for (int i = 3; i < 1024; i++) put_byte(i[7:0]);
        repeat (4) @(posedge clk_in);
        #2;
        chk(buffered_kb_out, 1, "kilobytes shown");
        chk(exp_q.size(), 0, "moves left over");
        chk(pops, 1024, "all moves out");
        repeat (60) @(posedge clk_in);
        put_byte(8'h44);
        repeat (3) @(posedge clk_in);
        #2;
        chk(buffered_kb_out, 0, "stale data overwritten");
    endtask

    task automatic t_stop_and_abort;
        press(K_RUN);
        chk(mode_out, EMC_STOP, "run in start");
        chk(host_ready_out, 0, "no data in stop");
        press(K_RUN);
        motion_busy_in = 1'b1;
        press(K_RUN);
        chk(mode_out, EMC_LIFT, "abort lifts");
        chk({xy_halt_out, z_lift_out, spindle_en_out}, 3'b110, "abort drive");
        z_at_top_in = 1'b1;
        repeat (6) @(posedge clk_in);
        #2;
        chk(mode_out, EMC_STOP, "stop after lift");
        z_at_top_in = 1'b0;
        motion_busy_in = 1'b0;
    endtask

    task automatic t_settings;
        press(K_SET);
        chk(mode_out, EMC_SET, "settings key");
        press(K_DOWN);
        chk(page_out, 2, "page down");
        repeat (2) press(K_UP);
        chk(page_out, PAGE_FIRST, "page clamp");
        item_has_action_in = 1'b1;
        press(K_ENTER);
        press(K_EXIT);
        chk(starts, 1, "execute pulses");
        chk(cancels, 1, "cancel pulses");
        chk(mode_out, EMC_SET, "cancel stays");
        item_has_action_in = 1'b0;
        press(K_EXIT);
        chk(mode_out, EMC_STOP, "exit to stop");
    endtask

    task automatic t_estop;
        press(K_RUN);
        move_ready_in = 1'b0;
        put_byte(8'h55);
        estop_latched_in = 1'b1;
        repeat (6) @(posedge clk_in);
        #2;
        exp_q.delete();
        chk({power_on_out, move_valid_out, host_ready_out}, 0, "estop cuts");
        pulse_power();
        chk(power_on_out, 0, "request while latched");
        estop_latched_in = 1'b0;
        repeat (8) @(posedge clk_in);
        #2;
        chk(power_on_out, 0, "release keeps off");
        pulse_power();
        chk({power_on_out, mode_out}, {1'b1, EMC_STOP}, "power back");
        move_ready_in = 1'b1;
        press(K_RUN);
        chk(move_valid_out, 0, "buffer discarded");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_in);
        #2;
        resetn_in = 1'b1;
        t_reset_and_idle_keys();
        t_override();
        t_stream();
        t_stop_and_abort();
        t_settings();
        t_estop();
        end_sim();
    end

    // a hang anywhere ends the run as a failure
    initial begin
        repeat (60000) @(posedge clk_in);
        miscompares++;
        $display("ERROR at %0t: run timed out", $time);
        end_sim();
    end
endmodule
`default_nettype wire
